//--- logic/motor_consts.svh
// Object indices, reset values and timing constants of the standstill and brake block
`ifndef MOTOR_CONSTS_SVH
`define MOTOR_CONSTS_SVH
`define IDX_IDLE 16'h2036
`define IDX_FACTOR 16'h2037
`define IDX_BRAKE 16'h2038
`define IDX_CURR 16'h2039
`define SUB_TOP 8'h00
`define SUB_ONE 8'h01
`define BRAKE_SUBS 8'h06
`define CURR_SUBS 8'h04
`define SUB_FREQ 8'h05
`define SUB_DUTY 8'h06
`define BRK_CLOSE 3'h0
`define BRK_SHUT 3'h1
`define BRK_OPEN 3'h2
`define BRK_START 3'h3
`define BRK_FREQ 3'h4
`define BRK_DUTY 3'h5
`define RST_IDLE 32'h3e8
`define RST_FACTOR 32'hfffffce
`define RST_DELAY 32'h3e8
`define RST_START 32'h0
`define RST_PWM 32'h0
`define FREQ_MAX 32'h7d0
`define DUTY_MIN 32'h2
`define DUTY_MAX 32'h64
`define PCT_BASE 32'h64
`define PCT_MIN 32'hffffff9c
`define PCT_DIV 39'h64
`define DUTY_DIV 64'h64
`define CLK_HZ 32'd40000000
`define CLK_NS 25
`define MS_NS 1000000
`endif

//--- logic/motor_pkg.sv
// Types shared by the standstill and brake block
package motor_pkg;
    // Sequencer states, Gray coded along power-up and shutdown
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_OPEN_WAIT = 3'h1,
        ST_START_WAIT = 3'h3,
        ST_RUN = 3'h2,
        ST_CLOSE_WAIT = 3'h6,
        ST_SHUT_WAIT = 3'h4
    } seq_state_t;
    typedef logic [3:0][31:0] cur_set_t;
endpackage

//--- logic/brake_if.sv
// Signals between the sequencer and the brake PWM driver
`timescale 1ns/10ps
interface brake_if;
    logic release_brake;
    logic [31:0] freq;
    logic [31:0] duty;
    logic pwm;
    modport ctrl (output release_brake, freq, duty, input pwm);
    modport drv (input release_brake, freq, duty, output pwm);
endinterface

//--- logic/brake_pwm.sv
// Brake PWM driver: programmable frequency in hertz and duty in percent
`timescale 1ns/10ps
`include "motor_consts.svh"
module brake_pwm (
    input wire logic clk_i,   // System clock
    input wire logic nrst_i,  // Async reset, active low
    brake_if.drv brk          // Release request and PWM settings
);
    logic [31:0] cnt_ff, nxt_cnt;
    logic pwm_ff, nxt_pwm;
    logic [31:0] period;
    logic [63:0] high_full;
    logic [31:0] high;
    logic steady;

    // Period and high time in clock cycles
    assign steady = (brk.freq == 32'h0) || (brk.duty == 32'h0);
    assign period = steady ? 32'h1 : (`CLK_HZ / brk.freq);
    assign high_full = (64'(period) * 64'(brk.duty)) / `DUTY_DIV;
    assign high = high_full[31:0];

    // Counter and output level
    always_comb begin
        nxt_cnt = 32'h0;
        nxt_pwm = 1'b0;
        if (brk.release_brake) begin
            if (steady) begin
                nxt_pwm = 1'b1; // R10 R11
            end else begin
                nxt_cnt = (cnt_ff >= period - 32'h1) ? 32'h0 : cnt_ff + 32'h1; // R10
                nxt_pwm = nxt_cnt < high; // R11
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= 32'h0;
            pwm_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pwm_ff <= nxt_pwm;
        end
    end

    assign brk.pwm = pwm_ff;

    pwm_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
        !brk.release_brake |=> !pwm_ff) else $error("brake pwm active while engaged");
    pwm_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
        cnt_ff < period || !brk.release_brake || $changed(brk.freq) || $changed(brk.duty))
        else $error("pwm counter beyond period");
endmodule

//--- logic/standstill_brake.sv
// Standstill current reduction, brake sequencing and measured current objects
`timescale 1ns/10ps
`include "motor_consts.svh"
// Overview of operation
// [R1] Reduction starts only after continuous standstill for idle time in ms, default 1000.
// [R2] Reduction only while the reduction enable bit is one and motor stands still.
// [R3] Non-negative setting below rated current gives reduced current equal to setting, mA.
// [R4] Setting -1 to -100 gives rated times (setting plus 100) over 100.
// [R5] Brake delays are in ms; close, shutdown, open default 1000, start 0.
// [R6] After standstill, wait close delay, then engage the brake.
// [R7] After engaging the brake, wait shutdown delay, then switch winding current off.
// [R8] On power-up switch current on, wait open delay, then release the brake.
// [R9] After release, wait start delay before entering operation enabled.
// [R10] Brake output is a PWM at the programmed frequency, accepted 0 to 2000 Hz.
// [R11] Brake PWM duty in percent, accepted 0 or 2 to 100.
// [R12] Four read-only signed measured currents: direct, quadrature, phase A, phase B.
// [R13] Direct and quadrature currents read zero unless closed loop is active.
// [R14] Percentage result uses integer arithmetic truncated toward zero.
// [R15] Leaving standstill restarts the idle counter and restores full current.
module standstill_brake #(
    parameter int TICK_CYCLES = `MS_NS / `CLK_NS  // Clock cycles per millisecond
) (
    input wire logic clk_i,                  // System clock, 40 MHz
    input wire logic nrst_i,                 // Async reset, active low
    input wire logic req_i,                  // Object access request pulse
    input wire logic wr_i,                   // Access is a write
    input wire logic [15:0] index_i,         // Object index
    input wire logic [7:0] subidx_i,         // Object subindex
    input wire logic [31:0] wdata_i,         // Write data
    output logic [31:0] rdata_o,             // Read data
    output logic ack_o,                      // Access done pulse
    output logic err_o,                      // Access refused pulse
    input wire logic power_req_i,            // Drive power requested
    input wire logic standstill_i,           // Motor at standstill
    input wire logic closed_loop_i,          // Closed loop active
    input wire logic reduce_en_i,            // Current reduction enable bit
    input wire logic [31:0] rated_current_i, // Rated current, mA rms
    input motor_pkg::cur_set_t meas_i,       // Measured d, q, a, b currents
    output logic winding_on_o,               // Winding current on
    output logic brake_o,                    // Brake drive, high releases
    output logic op_enabled_o,               // Operation enabled
    output logic reduce_active_o,            // Reduced current in force
    output logic [31:0] current_set_o        // Current setpoint, mA rms
);
    import motor_pkg::*;
    seq_state_t state_ff, nxt_state;
    logic [31:0] idle_ff, nxt_idle, factor_ff, nxt_factor;
    logic [31:0] brk_ff [0:5], nxt_brk [0:5];
    logic [31:0] rdata_ff, nxt_rdata;
    logic ack_ff, nxt_ack, err_ff, nxt_err;
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick_ff, nxt_tick;
    logic [31:0] idle_ms_ff, nxt_idle_ms, seq_ms_ff, nxt_seq_ms;
    logic reduce_ff, nxt_reduce;
    logic [31:0] current_ff, nxt_current, reduced;
    cur_set_t cur_ff, nxt_cur;
    logic [2:0] bidx;
    logic idle_done, in_pct, bad_val;
    logic [6:0] pct;
    logic [38:0] prod, quot;
    brake_if brk ();

    // Millisecond tick
    always_comb begin
        nxt_tick = tick_cnt_ff == 32'(TICK_CYCLES - 1);
        nxt_tick_cnt = nxt_tick ? 32'h0 : tick_cnt_ff + 32'h1; // R5
    end

    // Standstill idle counter and reduction gate
    assign idle_done = idle_ff == 32'h0 || idle_ms_ff > idle_ff; // R1
    always_comb begin
        nxt_idle_ms = idle_ms_ff;
        if (!standstill_i) begin
            nxt_idle_ms = 32'h0; // R15
        end else if (tick_ff && !idle_done) begin
            nxt_idle_ms = idle_ms_ff + 32'h1; // R1
        end
        nxt_reduce = reduce_en_i && standstill_i && idle_done && winding_on_o; // R1 R2
    end

    // Reduced current target
    assign in_pct = factor_ff[31] && ($signed(factor_ff) >= $signed(`PCT_MIN));
    assign pct = 7'(factor_ff + `PCT_BASE);
    assign prod = 39'(rated_current_i) * 39'(pct);
    assign quot = prod / `PCT_DIV; // R14
    assign reduced = quot[31:0];
    always_comb begin
        nxt_current = rated_current_i; // R15
        if (reduce_ff) begin
            if (!factor_ff[31] && factor_ff < rated_current_i) begin
                nxt_current = factor_ff; // R3
            end else if (in_pct) begin
                nxt_current = reduced; // R4
            end
        end
    end

    // Power and brake sequencer; a delay runs one extra tick, the first may come at once
    always_comb begin
        nxt_state = state_ff;
        nxt_seq_ms = tick_ff ? seq_ms_ff + 32'h1 : seq_ms_ff;
        case (state_ff)
            ST_OFF: begin
                nxt_seq_ms = 32'h0;
                if (power_req_i) begin
                    nxt_state = ST_OPEN_WAIT; // R8
                end
            end
            ST_OPEN_WAIT: begin
                if (brk_ff[`BRK_OPEN] == 32'h0 || seq_ms_ff > brk_ff[`BRK_OPEN]) begin
                    nxt_state = ST_START_WAIT; // R8
                end
            end
            ST_START_WAIT: begin
                if (brk_ff[`BRK_START] == 32'h0 || seq_ms_ff > brk_ff[`BRK_START]) begin
                    nxt_state = ST_RUN; // R9
                end
            end
            ST_RUN: begin
                nxt_seq_ms = 32'h0;
                if (!power_req_i) begin
                    nxt_state = ST_CLOSE_WAIT;
                end
            end
            ST_CLOSE_WAIT: begin
                if (power_req_i) begin
                    nxt_state = ST_RUN;
                end else if (!standstill_i) begin
                    nxt_seq_ms = 32'h0; // R6
                end else if (brk_ff[`BRK_CLOSE] == 32'h0 || seq_ms_ff > brk_ff[`BRK_CLOSE]) begin
                    nxt_state = ST_SHUT_WAIT; // R6
                end
            end
            ST_SHUT_WAIT: begin
                if (brk_ff[`BRK_SHUT] == 32'h0 || seq_ms_ff > brk_ff[`BRK_SHUT]) begin
                    nxt_state = ST_OFF; // R7
                end
            end
            default: begin
                nxt_state = ST_OFF;
            end
        endcase
        if (nxt_state != state_ff) begin
            nxt_seq_ms = 32'h0;
        end
    end

    // Object access: decode, range check, read mux
    assign bidx = subidx_i[2:0] - 3'h1;
    assign bad_val = (subidx_i == `SUB_FREQ && wdata_i > `FREQ_MAX) ||
        (subidx_i == `SUB_DUTY && wdata_i != 32'h0 &&
        (wdata_i < `DUTY_MIN || wdata_i > `DUTY_MAX));
    always_comb begin
        nxt_idle = idle_ff;
        nxt_factor = factor_ff;
        nxt_brk = brk_ff;
        nxt_rdata = rdata_ff;
        nxt_ack = req_i;
        nxt_err = 1'b0;
        if (req_i) begin
            nxt_rdata = 32'h0;
            case (index_i)
                `IDX_IDLE: begin
                    if (subidx_i != `SUB_TOP) nxt_err = 1'b1;
                    else if (wr_i) nxt_idle = wdata_i;
                    else nxt_rdata = idle_ff;
                end
                `IDX_FACTOR: begin
                    if (subidx_i != `SUB_TOP) nxt_err = 1'b1;
                    else if (wr_i) nxt_factor = wdata_i;
                    else nxt_rdata = factor_ff;
                end
                `IDX_BRAKE: begin
                    if (subidx_i == `SUB_TOP) begin
                        nxt_err = wr_i;
                        nxt_rdata = wr_i ? 32'h0 : 32'(`BRAKE_SUBS);
                    end else if (subidx_i > `BRAKE_SUBS) begin
                        nxt_err = 1'b1;
                    end else if (wr_i) begin
                        if (bad_val) nxt_err = 1'b1; // R10 R11
                        else nxt_brk[bidx] = wdata_i;
                    end else begin
                        nxt_rdata = brk_ff[bidx];
                    end
                end
                `IDX_CURR: begin
                    if (wr_i || subidx_i > `CURR_SUBS) begin
                        nxt_err = 1'b1;
                    end else if (subidx_i == `SUB_TOP) begin
                        nxt_rdata = 32'(`CURR_SUBS);
                    end else begin
                        nxt_rdata = cur_ff[bidx[1:0]]; // R12
                    end
                end
                default: begin
                    nxt_err = 1'b1;
                end
            endcase
        end
    end

    // Measured current capture, one entry per current
    for (genvar g = 0; g < 4; g++) begin : g_cur
        assign nxt_cur[g] = (g < 2 && !closed_loop_i) ? 32'h0 : meas_i[g]; // R12 R13
    end

    // State registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_OFF;
            idle_ff <= `RST_IDLE;
            factor_ff <= `RST_FACTOR;
            brk_ff[`BRK_CLOSE] <= `RST_DELAY; // R5
            brk_ff[`BRK_SHUT] <= `RST_DELAY;
            brk_ff[`BRK_OPEN] <= `RST_DELAY;
            brk_ff[`BRK_START] <= `RST_START;
            brk_ff[`BRK_FREQ] <= `RST_PWM;
            brk_ff[`BRK_DUTY] <= `RST_PWM;
            rdata_ff <= 32'h0;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            tick_cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
            idle_ms_ff <= 32'h0;
            seq_ms_ff <= 32'h0;
            reduce_ff <= 1'b0;
            current_ff <= 32'h0;
            cur_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            idle_ff <= nxt_idle;
            factor_ff <= nxt_factor;
            brk_ff <= nxt_brk;
            rdata_ff <= nxt_rdata;
            ack_ff <= nxt_ack;
            err_ff <= nxt_err;
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff <= nxt_tick;
            idle_ms_ff <= nxt_idle_ms;
            seq_ms_ff <= nxt_seq_ms;
            reduce_ff <= nxt_reduce;
            current_ff <= nxt_current;
            cur_ff <= nxt_cur;
        end
    end

    // Brake PWM driver
    assign brk.release_brake = state_ff == ST_START_WAIT || state_ff == ST_RUN ||
        state_ff == ST_CLOSE_WAIT; // R8
    assign brk.freq = brk_ff[`BRK_FREQ];
    assign brk.duty = brk_ff[`BRK_DUTY];
    brake_pwm u_pwm (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .brk(brk.drv)
    );
    // Outputs
    assign rdata_o = rdata_ff;
    assign ack_o = ack_ff;
    assign err_o = err_ff;
    assign winding_on_o = state_ff != ST_OFF; // R7 R8
    assign brake_o = brk.pwm;
    assign op_enabled_o = state_ff == ST_RUN || state_ff == ST_CLOSE_WAIT; // R9
    assign reduce_active_o = reduce_ff;
    assign current_set_o = current_ff;
    idle_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R1
        $rose(reduce_ff) |-> $past(standstill_i && (idle_ff == 32'h0 || idle_ms_ff > idle_ff)))
        else $error("reduction before idle time");
    reduce_en_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
        reduce_ff |-> $past(reduce_en_i && standstill_i)) else $error("reduction not enabled");
    abs_value_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
        reduce_ff && !factor_ff[31] && factor_ff < rated_current_i |=>
        current_ff == $past(factor_ff)) else $error("absolute reduction wrong");
    pct_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R4
        reduce_ff && factor_ff == `PCT_MIN |=> current_ff == 32'h0)
        else $error("full percent reduction not zero");
    idle_restart_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R15
        !standstill_i |=> idle_ms_ff == 32'h0 && !reduce_ff)
        else $error("standstill loss did not restart");
    close_delay_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
        $rose(state_ff == ST_SHUT_WAIT) |->
        $past(standstill_i && (brk_ff[`BRK_CLOSE] == 32'h0 || seq_ms_ff > brk_ff[`BRK_CLOSE])))
        else $error("brake closed early");
    shut_delay_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
        (state_ff == ST_SHUT_WAIT) ##1 (state_ff == ST_OFF) |->
        $past(brk_ff[`BRK_SHUT] == 32'h0 || seq_ms_ff > brk_ff[`BRK_SHUT]))
        else $error("winding off early");
    open_delay_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
        $rose(brk.release_brake) |->
        $past(winding_on_o && (brk_ff[`BRK_OPEN] == 32'h0 || seq_ms_ff > brk_ff[`BRK_OPEN])))
        else $error("brake opened early");
    start_delay_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R9
        $rose(op_enabled_o) |-> $past(brk.release_brake) &&
        $past(brk_ff[`BRK_START] == 32'h0 || seq_ms_ff > brk_ff[`BRK_START]))
        else $error("operation enabled early");
    pwm_range_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10 R11
        brk_ff[`BRK_FREQ] <= `FREQ_MAX && brk_ff[`BRK_DUTY] <= `DUTY_MAX &&
        brk_ff[`BRK_DUTY] != 32'h1) else $error("pwm setting out of range");
    dq_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R13
        !closed_loop_i |=> cur_ff[0] == 32'h0 && cur_ff[1] == 32'h0)
        else $error("d or q current shown in open loop");
endmodule

//--- tb/stage_model.sv
// Model of the power stage and brake driver facing the sequencer
`timescale 1ns/10ps
module stage_model #(
    parameter motor_pkg::cur_set_t MEAS = '0 // Currents the stage reports
) (
    input wire logic clk_i,            // System clock
    input wire logic move_i,           // Motion commanded
    input wire logic brake_i,          // Brake drive, high releases
    output logic standstill_o,         // Shaft at rest
    output motor_pkg::cur_set_t meas_o, // Measured d, q, a, b currents
    output logic [31:0] high_o,        // Last brake high time, cycles
    output logic [31:0] period_o       // Last brake period, cycles
);
    import motor_pkg::*;
    logic [31:0] hcnt_ff = 32'h0;
    logic [31:0] pcnt_ff = 32'h0;
    logic brake_ff = 1'b0;
    initial standstill_o = 1'b1;
    initial high_o = 32'h0;
    initial period_o = 32'h0;
    // Sensors report fixed currents
    assign meas_o = MEAS;
    // Shaft settles one cycle after motion stops
    always @(posedge clk_i) begin
        standstill_o <= ~move_i;
    end
    // Time each brake pulse from rising edge to rising edge
    always @(posedge clk_i) begin
        brake_ff <= brake_i;
        if (brake_i && !brake_ff) begin
            period_o <= pcnt_ff;
            high_o <= hcnt_ff;
            pcnt_ff <= 32'h1;
            hcnt_ff <= 32'h1;
        end else begin
            pcnt_ff <= pcnt_ff + 32'h1;
            hcnt_ff <= hcnt_ff + {31'h0, brake_i};
        end
    end
endmodule

//--- tb/test_standstill_brake.sv
// Testbench of the standstill reduction and brake sequencer
`timescale 1ns/10ps
module test_standstill_brake;
    import motor_pkg::*;
    localparam cur_set_t MEAS = {32'hc8, 32'hffffff38, 32'h1f4, 32'hfffffc18};
    localparam int PER = 40000000 / 2000;
    localparam int HI = PER * 2 / 100;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_i = 1'b0;
    logic wr_i = 1'b0;
    logic [15:0] index_i = 16'h0;
    logic [7:0] subidx_i = 8'h0;
    logic [31:0] wdata_i = 32'h0;
    logic power_req_i = 1'b0;
    logic closed_loop_i = 1'b0;
    logic reduce_en_i = 1'b0;
    logic [31:0] rated_current_i = 32'h3e9;
    logic move_i = 1'b0;
    logic [31:0] rdata_o, current_set_o, high, period;
    logic ack_o, err_o, standstill_i, winding_on_o, brake_o, op_enabled_o, reduce_active_o;
    cur_set_t meas_i;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    int fac[6] = '{-33, -100, -1, 500, 1001, 0};
    int exf[6] = '{670, 0, 990, 500, 1001, 0};

    always #12.5 clk_i = ~clk_i;

    standstill_brake #(.TICK_CYCLES(4)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i),
        .wr_i(wr_i), .index_i(index_i), .subidx_i(subidx_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o), .power_req_i(power_req_i),
        .standstill_i(standstill_i), .closed_loop_i(closed_loop_i), .reduce_en_i(reduce_en_i),
        .rated_current_i(rated_current_i), .meas_i(meas_i), .winding_on_o(winding_on_o),
        .brake_o(brake_o), .op_enabled_o(op_enabled_o), .reduce_active_o(reduce_active_o),
        .current_set_o(current_set_o));

    stage_model #(.MEAS(MEAS)) i_stage (.clk_i(clk_i), .move_i(move_i), .brake_i(brake_o),
        .standstill_o(standstill_i), .meas_o(meas_i), .high_o(high), .period_o(period));

    // Compare one value and count it
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // Compare a cycle count against a window
    task win(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
            fail_count++;
        end
    endtask

    // One object access with its answer checked
    task acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
             input logic [31:0] d, input logic e, input logic [31:0] exp);
        @(posedge clk_i);
        req_i <= 1'b1;
        wr_i <= w;
        index_i <= idx;
        subidx_i <= sub;
        wdata_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        #1;
        chk("ack", 32'h1, {31'h0, ack_o});
        chk("err", {31'h0, e}, {31'h0, err_o});
        chk("rdata", exp, rdata_o);
    endtask

    task rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
        acc(1'b0, idx, sub, 32'h0, 1'b0, exp);
    endtask

    task wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
        acc(1'b1, idx, sub, d, e, 32'h0);
    endtask

    function logic pick(input int sel);
        case (sel)
            0: return winding_on_o;
            1: return brake_o;
            2: return op_enabled_o;
            default: return reduce_active_o;
        endcase
    endfunction

    // Count cycles until an output reaches a level, bounded
    task wsig(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        #1;
        while (pick(sel) !== lvl && cnt < 4000) begin
            @(posedge clk_i);
            #1;
            cnt++;
        end
    endtask

    // Counts and verdict, then stop
    task conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 60000) begin
            fail_count++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(16'h2036, 8'h0, 32'h3e8);
        rd(16'h2037, 8'h0, 32'h0fffffce);
        rd(16'h2038, 8'h0, 32'h6);
        for (int s = 1; s <= 6; s++) rd(16'h2038, s[7:0], s < 4 ? 32'h3e8 : 32'h0);
        rd(16'h2039, 8'h0, 32'h4);
        $display("defaults done");
        acc(1'b0, 16'h2035, 8'h0, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 16'h2036, 8'h1, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 16'h2038, 8'h7, 32'h0, 1'b1, 32'h0);
        acc(1'b0, 16'h2039, 8'h5, 32'h0, 1'b1, 32'h0);
        wr(16'h2038, 8'h0, 32'h5, 1'b1);
        wr(16'h2039, 8'h1, 32'h5, 1'b1);
        wr(16'h2038, 8'h5, 32'h7d1, 1'b1);
        rd(16'h2038, 8'h5, 32'h0);
        wr(16'h2038, 8'h5, 32'h7d0, 1'b0);
        rd(16'h2038, 8'h5, 32'h7d0);
        wr(16'h2038, 8'h5, 32'h0, 1'b0);
        wr(16'h2038, 8'h6, 32'h1, 1'b1);
        wr(16'h2038, 8'h6, 32'h65, 1'b1);
        wr(16'h2038, 8'h6, 32'h2, 1'b0);
        rd(16'h2038, 8'h6, 32'h2);
        wr(16'h2038, 8'h6, 32'h64, 1'b0);
        rd(16'h2038, 8'h6, 32'h64);
        wr(16'h2038, 8'h6, 32'h0, 1'b0);
        $display("access checks done");
        for (int c = 0; c < 2; c++) begin
            @(posedge clk_i);
            closed_loop_i <= c[0];
            for (int s = 1; s <= 4; s++) begin
                rd(16'h2039, s[7:0], (c == 0 && s < 3) ? 32'h0 : MEAS[s-1]);
            end
        end
        $display("current objects done");
        wr(16'h2038, 8'h1, 32'h2, 1'b0);
        wr(16'h2038, 8'h2, 32'h3, 1'b0);
        wr(16'h2038, 8'h3, 32'h2, 1'b0);
        wr(16'h2038, 8'h4, 32'h1, 1'b0);
        @(posedge clk_i);
        power_req_i <= 1'b1;
        wsig(0, 1'b1, n);
        win("winding on", 0, 3, n);
        chk("brake at power on", 32'h0, {31'h0, brake_o});
        wsig(1, 1'b1, n);
        win("brake release", 8, 15, n);
        wsig(2, 1'b1, n);
        win("operation enabled", 3, 11, n);
        $display("power up done");
        wr(16'h2036, 8'h0, 32'h3, 1'b0);
        @(posedge clk_i);
        reduce_en_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(16'h2037, 8'h0, fac[i], 1'b0);
            @(posedge clk_i);
            move_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            #1;
            chk("reduce on motion", 32'h0, {31'h0, reduce_active_o});
            chk("full current", rated_current_i, current_set_o);
            @(posedge clk_i);
            move_i <= 1'b0;
            wsig(3, 1'b1, n);
            win("idle time", 12, 22, n);
            repeat (2) @(posedge clk_i);
            #1;
            chk("reduced current", exf[i], current_set_o);
        end
        @(posedge clk_i);
        move_i <= 1'b1;
        reduce_en_i <= 1'b0;
        @(posedge clk_i);
        move_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        #1;
        chk("reduce disabled", 32'h0, {31'h0, reduce_active_o});
        chk("disabled current", rated_current_i, current_set_o);
        $display("reduction done");
        wr(16'h2038, 8'h5, 32'h7d0, 1'b0);
        wr(16'h2038, 8'h6, 32'h2, 1'b0);
        repeat (42000) @(posedge clk_i);
        #1;
        chk("pwm period", PER, period);
        chk("pwm high", HI, high);
        wr(16'h2038, 8'h6, 32'h0, 1'b0);
        repeat (3) @(posedge clk_i);
        #1;
        chk("duty zero steady", 32'h1, {31'h0, brake_o});
        wr(16'h2038, 8'h5, 32'h0, 1'b0);
        $display("pwm done");
        @(posedge clk_i);
        move_i <= 1'b1;
        power_req_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        chk("brake held while moving", 32'h1, {31'h0, brake_o});
        @(posedge clk_i);
        move_i <= 1'b0;
        wsig(1, 1'b0, n);
        win("brake engage", 8, 16, n);
        chk("operation off", 32'h0, {31'h0, op_enabled_o});
        wsig(0, 1'b0, n);
        win("winding off", 11, 19, n);
        $display("shutdown done");
        conclude();
    end
endmodule
